// file: inc/sfic_pkg.sv
// Purpose: Constants for the supply fault impact configuration block
// Assumes: APB slave with 32-bit data, one 16-bit register
// Notes:   Functional notes below list the behaviour kept by the block
//
// Functional notes
// - Monitor two undervoltage drives enabled outputs, bits 0-2
// - Monitor two overvoltage drives enabled outputs, bits 3-5
// - Monitor one undervoltage drives enabled outputs, bits 7-9
// - Monitor one overvoltage drives enabled outputs, bits 10-12
// - Reset-output enables load from fuses, not fixed
// - Other enables reset to one, except monitor-two undervoltage
package sfic_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int APB_AW = 12;                  // Address width
   localparam int APB_DW = 32;                  // Data width
   localparam int CFG_W = 16;                   // Register width

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [APB_AW-1:0] CFG1_OFFSET = 12'h000;

   // ----------------------------------------------------------------
   // Field positions: base of each source, then target offset
   // ----------------------------------------------------------------
   localparam int MON2_UNDER_BASE = 0;          // Bits 0..2
   localparam int MON2_OVER_BASE = 3;           // Bits 3..5
   localparam int MON1_UNDER_BASE = 7;          // Bits 7..9
   localparam int MON1_OVER_BASE = 10;          // Bits 10..12
   localparam int TGT_LIMP = 0;                 // Limp-home target
   localparam int TGT_FAILSAFE = 1;             // Fail-safe target
   localparam int TGT_RESET = 2;                // Reset target

   // Fault vector order: {mon1 over, mon1 under, mon2 over, mon2 under}
   localparam int FLT_W = 4;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [CFG_W-1:0] CFG1_POR = 16'h0d98;   // Limp/fail-safe
   localparam logic [CFG_W-1:0] CFG1_FUSE_MASK = 16'h1224; // Reset enables
   localparam logic [CFG_W-1:0] CFG1_IMPL_MASK = 16'h1fbf; // Live bits

   // ----------------------------------------------------------------
   // Synchroniser depth
   // ----------------------------------------------------------------
   localparam int SYNC_STAGES = 2;

endpackage

// file: design/sfic_sync.sv
// Purpose: Multi-bit two-flop synchroniser for pin inputs
// Assumes: Each bit is an independent slow level
// Notes:   First stage is read only by the second stage
module sfic_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   import sfic_pkg::*;

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] meta_r; // Metastability catcher
   logic [WIDTH-1:0] stab_r; // Settled copy

   // Two flops; width check up front
   initial begin
      if (WIDTH < 1) begin
         $error("sfic_sync: WIDTH must be at least one");
      end
   end

   // Pipeline shifts every edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         stab_r <= '0;
      end else begin
         meta_r <= d;
         stab_r <= meta_r;
      end
   end

   assign q = stab_r;

endmodule

// file: design/sfic_top.sv
// Purpose: Routes supply monitor faults to reset, fail-safe, limp-home
// Assumes: APB master on SYS_CLK; pins asynchronous to SYS_CLK
// Notes:   Outputs are active-high assertion requests, all registered
//
// Design decisions made here: the placing of the registers and the APB slave port.
module sfic_top #(
   parameter int ADDR_W = sfic_pkg::APB_AW
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [sfic_pkg::APB_DW-1:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [sfic_pkg::APB_DW-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Monitor fault pins (asynchronous levels)
   input wire logic MON1_UNDER,
   input wire logic MON1_OVER,
   input wire logic MON2_UNDER,
   input wire logic MON2_OVER,
   // Fuse load: reset-output enables {m1 ov, m1 uv, m2 ov, m2 uv}
   input wire logic [sfic_pkg::FLT_W-1:0] FUSE_RESET_EN,
   input wire logic FUSE_VALID,
   // Target requests
   output logic LIMP_HOME_ASSERT,
   output logic FAILSAFE_ASSERT,
   output logic RESET_ASSERT
);
   import sfic_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   initial begin
      if (ADDR_W < 3 || ADDR_W > 32) begin
         $error("sfic_top: ADDR_W must lie in 3..32");
      end
   end

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_pipe_r; // Release pipeline
   logic rst_n_s; // Synchronised reset

   // Asserts at once, releases after two edges
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_pipe_r <= 2'h0;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_n_s = rst_pipe_r[1];

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [FLT_W-1:0] flt_s; // {m1 ov, m1 uv, m2 ov, m2 uv}
   logic [FLT_W-1:0] fuse_s; // Synced fuse bits
   logic fuse_vld_s; // Synced fuse valid

   sfic_sync #(
      .WIDTH(2 * FLT_W + 1)
   ) u_sync (
      .clk(SYS_CLK),
      .rst_n(rst_n_s),
      .d({FUSE_VALID, FUSE_RESET_EN,
          MON1_OVER, MON1_UNDER, MON2_OVER, MON2_UNDER}),
      .q({fuse_vld_s, fuse_s, flt_s})
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Scatter four fuse bits onto the reset-enable positions
   function automatic logic [CFG_W-1:0] fuse_map(
      input logic [FLT_W-1:0] f
   );
      logic [CFG_W-1:0] v;
      v = '0;
      v[MON2_UNDER_BASE + TGT_RESET] = f[0];
      v[MON2_OVER_BASE + TGT_RESET] = f[1];
      v[MON1_UNDER_BASE + TGT_RESET] = f[2];
      v[MON1_OVER_BASE + TGT_RESET] = f[3];
      return v;
   endfunction

   // OR of every active fault whose enable for this target is set
   function automatic logic route(
      input logic [CFG_W-1:0] c,
      input logic [FLT_W-1:0] f,
      input int tgt
   );
      logic hit;
      hit = 1'b0;
      hit = hit | (f[0] & c[MON2_UNDER_BASE + tgt]);
      hit = hit | (f[1] & c[MON2_OVER_BASE + tgt]);
      hit = hit | (f[2] & c[MON1_UNDER_BASE + tgt]);
      hit = hit | (f[3] & c[MON1_OVER_BASE + tgt]);
      return hit;
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic hit_cfg; // Address hits the register
   logic [ADDR_W-1:0] cfg_addr; // Register offset at bus width
   logic setup; // Setup phase of a transfer
   logic wr_en; // Write commits this edge
   logic [CFG_W-1:0] cfg_r; // Configuration register
   logic [CFG_W-1:0] wmask; // Writable bits from strobes
   logic [CFG_W-1:0] cfg_wr; // Value after a write
   logic fuse_done_r; // Fuse copy taken

   // Offset resized on purpose so any legal ADDR_W selects in range
   assign cfg_addr = ADDR_W'(CFG1_OFFSET);
   assign hit_cfg = (PADDR[ADDR_W-1:2] == cfg_addr[ADDR_W-1:2]);
   assign setup = PSEL && !PENABLE;
   // Commit only on the access edge where ready is seen
   assign wr_en = PSEL && PENABLE && PREADY && PWRITE && hit_cfg;
   // Byte strobes gate each half; unused bits never store
   assign wmask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}} & CFG1_IMPL_MASK;
   assign cfg_wr = (cfg_r & ~wmask) | (PWDATA[CFG_W-1:0] & wmask);

   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   // Reset enables start clear until fuses arrive; the rest take POR.
   // A fuse load in the same edge as a write wins on the fuse bits,
   // so a stale write cannot mask the factory setting.
   always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         cfg_r <= CFG1_POR;
      end else if (fuse_vld_s && !fuse_done_r) begin
         cfg_r <= ((wr_en ? cfg_wr : cfg_r) & ~CFG1_FUSE_MASK)
                  | fuse_map(fuse_s);
      end else if (wr_en) begin
         cfg_r <= cfg_wr;
      end
   end

   // Fuse load happens once per reset
   always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         fuse_done_r <= 1'b0;
      end else if (fuse_vld_s) begin
         fuse_done_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // One wait-free access cycle: ready rises for the access phase
   always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= '0;
      end else if (setup) begin
         PREADY <= 1'b1;
         PSLVERR <= !hit_cfg; // Unmapped address errors
         // Reserved and upper bits read zero
         PRDATA <= (!PWRITE && hit_cfg) ?
                   {{(APB_DW-CFG_W){1'b0}}, cfg_r & CFG1_IMPL_MASK} :
                   '0;
      end else begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Target outputs
   // ----------------------------------------------------------------
   // Registered so the pins never glitch on enable changes
   always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         LIMP_HOME_ASSERT <= 1'b0;
         FAILSAFE_ASSERT <= 1'b0;
         RESET_ASSERT <= 1'b0;
      end else begin
         LIMP_HOME_ASSERT <= route(cfg_r, flt_s, TGT_LIMP);
         FAILSAFE_ASSERT <= route(cfg_r, flt_s, TGT_FAILSAFE);
         RESET_ASSERT <= route(cfg_r, flt_s, TGT_RESET);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!rst_n_s);

   mon2_under_a: assert property (
      flt_s[0] && cfg_r[0] && cfg_r[1] && cfg_r[2]
      |=> LIMP_HOME_ASSERT && FAILSAFE_ASSERT && RESET_ASSERT)
      else $error("Monitor two undervoltage not routed");

   mon2_over_a: assert property (
      flt_s[1] && cfg_r[3] && cfg_r[4] && cfg_r[5]
      |=> LIMP_HOME_ASSERT && FAILSAFE_ASSERT && RESET_ASSERT)
      else $error("Monitor two overvoltage not routed");

   mon1_under_a: assert property (
      flt_s[2] && cfg_r[7] && cfg_r[8] && cfg_r[9]
      |=> LIMP_HOME_ASSERT && FAILSAFE_ASSERT && RESET_ASSERT)
      else $error("Monitor one undervoltage not routed");

   mon1_over_a: assert property (
      flt_s[3] && cfg_r[10] && cfg_r[11] && cfg_r[12]
      |=> LIMP_HOME_ASSERT && FAILSAFE_ASSERT && RESET_ASSERT)
      else $error("Monitor one overvoltage not routed");

   fuse_load_a: assert property (
      $rose(fuse_done_r) |->
      {cfg_r[12], cfg_r[9], cfg_r[5], cfg_r[2]} == $past(fuse_s))
      else $error("Reset enables differ from fuse copy");

   por_value_a: assert property (
      $rose(rst_n_s) |-> (cfg_r == CFG1_POR) ##1
      ((cfg_r & ~CFG1_FUSE_MASK) == ($past(wr_en) ?
       ($past(cfg_wr) & ~CFG1_FUSE_MASK) : (CFG1_POR & ~CFG1_FUSE_MASK))))
      else $error("Enables did not start at power-on value");

   reset_or_a: assert property (
      ##1 RESET_ASSERT == $past(
         (flt_s[0] & cfg_r[2]) | (flt_s[1] & cfg_r[5]) |
         (flt_s[2] & cfg_r[9]) | (flt_s[3] & cfg_r[12])))
      else $error("Reset request is not the OR of sources");

   limp_or_a: assert property (
      ##1 LIMP_HOME_ASSERT == $past(
         (flt_s[0] & cfg_r[0]) | (flt_s[1] & cfg_r[3]) |
         (flt_s[2] & cfg_r[7]) | (flt_s[3] & cfg_r[10])))
      else $error("Limp-home request is not the OR of sources");

   failsafe_or_a: assert property (
      ##1 FAILSAFE_ASSERT == $past(
         (flt_s[0] & cfg_r[1]) | (flt_s[1] & cfg_r[4]) |
         (flt_s[2] & cfg_r[8]) | (flt_s[3] & cfg_r[11])))
      else $error("Fail-safe request is not the OR of sources");

   unused_zero_a: assert property (
      (cfg_r & ~CFG1_IMPL_MASK) == '0 && PRDATA[APB_DW-1:CFG_W] == '0
      && !(PREADY && PRDATA[6]))
      else $error("Unused bits not zero");

endmodule

// file: testbench/test_sfic_top.sv
// Purpose: Self-checking bench for the supply fault impact block
// Assumes: APB slave answers with its own pready; pins are slow levels
// Notes:   Routing rows run in one loop; reset and edge cases follow it
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("unexpected %s exp %h seen %h", nm, e, g); \
   end end
module test_sfic_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sfic_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observation
   // ----------------------------------------------------------------
   typedef struct {
      logic [CFG_W-1:0] cfg;  // Enable pattern to write
      logic [FLT_W-1:0] flt;  // Faults {m1 over, m1 under, m2 over, m2 under}
      logic [2:0] exp;        // Expected {reset, fail-safe, limp}
   } sfic_row_t;
   logic clk, rst_n, psel, penable, pwrite, fuse_vld, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [3:0] pstrb, flt, fuse_en;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, limp, fs, rst;
   int fail_count = 0;
   int total_checks = 0;
   // Rows enable or block paths of one source; row 9 has no fault, row 10 tests the OR, row 11 unused bit 6
   sfic_row_t rows [12] = '{
      '{16'h0007, 4'h1, 3'h7},
      '{16'h0001, 4'h1, 3'h1}, '{16'h0002, 4'h1, 3'h2},
      '{16'h0004, 4'h1, 3'h4}, '{16'h1fb8, 4'h1, 3'h0},
      '{16'h0008, 4'h2, 3'h1}, '{16'h0030, 4'h2, 3'h6},
      '{16'h0380, 4'h4, 3'h7}, '{16'h1c00, 4'h8, 3'h7},
      '{16'h1fbf, 4'h0, 3'h0}, '{16'h0401, 4'h9, 3'h1},
      '{16'h0040, 4'hf, 3'h0}};
   sfic_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MON1_UNDER(flt[2]), .MON1_OVER(flt[3]), .MON2_UNDER(flt[0]),
      .MON2_OVER(flt[1]), .FUSE_RESET_EN(fuse_en), .FUSE_VALID(fuse_vld),
      .LIMP_HOME_ASSERT(limp), .FAILSAFE_ASSERT(fs), .RESET_ASSERT(rst));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // One APB transfer; waits for pready rather than assuming a latency
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      // Request stands until a rising edge sees pready high
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fail_count++;
         $display("unexpected pready exp 1 seen %b", pready);
      end
      // Answer taken at that same edge, then the request is released
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task note(input string s);
      $display("test %s done", s);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The tests need well under 1500 cycles; this span is generous
   initial begin
      #50000;
      fail_count++;
      $display("unexpected watchdog exp done seen hang");
      wrap_up();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, psel, penable, pwrite, fuse_vld} = 5'h00;
      {paddr, pwdata, pstrb, flt} = '0;
      fuse_en = 4'ha;  // Fuse copy is stable long before it is valid
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Power-on value, reset enables still empty before the fuse load
      apb(1'b0, CFG1_OFFSET, 32'h0000_0000, 4'h0);
      `CHK("por", 32'h0000_0d98, rd)
      `CHK("por outputs", 3'h0, {rst, fs, limp})
      note("power-on");
      @(posedge clk) fuse_vld <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, CFG1_OFFSET, 32'h0000_0000, 4'h0);
      `CHK("fuse load", 32'h0000_1db8, rd)
      note("fuse");
      foreach (rows[i]) begin
         apb(1'b1, CFG1_OFFSET, {16'h0000, rows[i].cfg}, 4'hf);
         @(posedge clk) flt <= rows[i].flt;
         repeat (4) @(posedge clk);
         @(negedge clk);
         `CHK("targets", rows[i].exp, {rst, fs, limp})
         @(posedge clk) flt <= 4'h0;
         repeat (4) @(posedge clk);
      end
      note("routing rows");
      // Low byte lane only; unused bit 6 must not store
      apb(1'b1, CFG1_OFFSET, 32'h0000_0000, 4'hf);
      apb(1'b1, CFG1_OFFSET, 32'hffff_ffff, 4'h1);
      apb(1'b0, CFG1_OFFSET, 32'h0000_0000, 4'h0);
      `CHK("lane write", 32'h0000_00bf, rd)
      `CHK("good err", 1'b0, er)
      note("byte lanes");
      // Unmapped word: refused, nothing stored
      apb(1'b1, 12'h004, 32'hffff_ffff, 4'hf);
      `CHK("bad write err", 1'b1, er)
      apb(1'b0, 12'h004, 32'h0000_0000, 4'h0);
      `CHK("bad read data", 32'h0000_0000, rd)
      `CHK("bad read err", 1'b1, er)
      apb(1'b0, CFG1_OFFSET, 32'h0000_0000, 4'h0);
      `CHK("after bad", 32'h0000_00bf, rd)
      note("unmapped");
      // Reset in mid-run with every fault active; fuse reloads after it
      @(posedge clk) flt <= 4'hf;
      @(posedge clk) rst_n <= 1'b0;
      @(negedge clk);
      `CHK("reset outputs", 3'h0, {rst, fs, limp})
      @(posedge clk) rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHK("rerun outputs", 3'h7, {rst, fs, limp})
      apb(1'b0, CFG1_OFFSET, 32'h0000_0000, 4'h0);
      `CHK("reload", 32'h0000_1db8, rd)
      note("second reset");
      wrap_up();
   end
endmodule
